// *** apm_power_mode_ctrl.sv ***
// active/sleep power-mode controller with register port and wake switches
// assumes sensed pins are asynchronous; protection verdicts come from mclk logic
`default_nettype none

module apm_power_mode_ctrl #(
  parameter int unsigned SLEEP_CYC = apm_pkg::SLEEP_CYC,
  parameter int unsigned DEBOUNCE_CYC = apm_pkg::DEBOUNCE_CYC
) (
  // clock and reset
  input wire logic mclk,
  input wire logic srst,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // sensed pins and comparators
  input wire logic bus_line_in,
  input wire logic aux_io_pin_in,
  input wire logic charger_detect_in,
  input wire logic charge_current_in,
  input wire logic cell_undervoltage_in,
  // protector verdicts
  input wire logic charge_safe,
  input wire logic discharge_safe,
  // function enables
  output logic active_mode,
  output logic measure_enable,
  output logic coulomb_count_enable,
  output logic auth_enable,
  output logic charge_fet_drive_enable,
  output logic discharge_fet_drive_enable,
  // weak pull-ups for wake switches
  output logic bus_pin_weak_pullup,
  output logic aux_io_pin_weak_pullup
);

  localparam int unsigned NSYNC = 5;
  localparam int unsigned S_BUS = 0;
  localparam int unsigned S_AUX = 1;
  localparam int unsigned S_CHG = 2;
  localparam int unsigned S_CUR = 3;
  localparam int unsigned S_UV = 4;

  // ==========================================================
  // input synchronisers
  logic [NSYNC-1:0] raw_in;
  logic [NSYNC-1:0] sync1_r;
  logic [NSYNC-1:0] sync2_r;

  assign raw_in = {cell_undervoltage_in, charge_current_in, charger_detect_in,
                   aux_io_pin_in, bus_line_in};

  genvar gi;
  generate
    for (gi = 0; gi < NSYNC; gi++)
    begin : g_sync
      always_ff @(posedge mclk)
      begin
        if (srst)
        begin
          sync1_r[gi] <= 1'b0;
          sync2_r[gi] <= 1'b0;
        end
        else
        begin
          sync1_r[gi] <= raw_in[gi];
          sync2_r[gi] <= sync1_r[gi];
        end
      end
    end
  endgenerate

  logic bus_s;
  logic uv_s;
  logic charger_s;
  logic chg_cur_s;
  assign bus_s = sync2_r[S_BUS];
  assign uv_s = sync2_r[S_UV];
  assign charger_s = sync2_r[S_CHG];
  assign chg_cur_s = sync2_r[S_CUR];

  // ==========================================================
  // register file
  logic [7:0] ctrl_r;
  logic [7:0] ctrl_nxt;
  logic [7:0] rdata_r;
  logic [7:0] rdata_nxt;
  logic [7:0] status;
  apm_pkg::apm_mode_t mode_r;
  apm_pkg::apm_mode_t mode_nxt;
  logic idle_qual;

  function automatic logic addr_hit(input logic [7:0] a, input logic [7:0] target);
    addr_hit = (a == target);
  endfunction

  always_comb
  begin
    status = 8'h00;
    status[apm_pkg::STAT_ACTIVE_BIT] = (mode_r == apm_pkg::APM_ACTIVE);
    status[apm_pkg::STAT_SLEEP_BUS_LOW_BIT] = (mode_r == apm_pkg::APM_SLEEP_BUS_LOW);
    status[apm_pkg::STAT_SLEEP_UV_BIT] = (mode_r == apm_pkg::APM_SLEEP_UV);
    status[apm_pkg::STAT_BUS_LEVEL_BIT] = bus_s;
    status[apm_pkg::STAT_UV_BIT] = uv_s;
    status[apm_pkg::STAT_CHARGER_BIT] = charger_s;
    status[apm_pkg::STAT_CHG_CURRENT_BIT] = chg_cur_s;
    status[apm_pkg::STAT_IDLE_QUAL_BIT] = idle_qual;
  end

  // the control register holds its value in every mode; only a write or srst changes it
  always_comb
  begin
    ctrl_nxt = ctrl_r;
    rdata_nxt = 8'h00;
    if (reg_wr && addr_hit(reg_addr, apm_pkg::CTRL_ADDR))
      ctrl_nxt = reg_wdata;
    if (reg_rd)
    begin
      if (addr_hit(reg_addr, apm_pkg::CTRL_ADDR))
        rdata_nxt = ctrl_r;
      else if (addr_hit(reg_addr, apm_pkg::STAT_ADDR))
        rdata_nxt = status;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      ctrl_r <= apm_pkg::CTRL_RST;
      rdata_r <= 8'h00;
    end
    else
    begin
      ctrl_r <= ctrl_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  assign reg_rdata = rdata_r;

  logic en_bus_low;
  logic en_uv;
  logic en_aux_ws;
  logic en_bus_ws;
  assign en_bus_low = ctrl_r[apm_pkg::SLEEP_ON_BUS_LOW_ENABLE_BIT];
  assign en_uv = ctrl_r[apm_pkg::SLEEP_ON_UNDERVOLTAGE_ENABLE_BIT];
  assign en_aux_ws = ctrl_r[apm_pkg::AUX_PIN_WAKE_SWITCH_ENABLE_BIT];
  assign en_bus_ws = ctrl_r[apm_pkg::BUS_PIN_WAKE_SWITCH_ENABLE_BIT];

  // ==========================================================
  // bus activity and sleep timeout
  logic bus_prev_r;
  logic bus_prev_nxt;
  logic [apm_pkg::CNT_W-1:0] idle_cnt_r;
  logic [apm_pkg::CNT_W-1:0] idle_cnt_nxt;
  logic bus_change;
  logic bus_rise;

  assign bus_change = (bus_s != bus_prev_r);
  assign bus_rise = bus_s && !bus_prev_r;
  assign idle_qual = (idle_cnt_r >= SLEEP_CYC);

  always_comb
  begin
    bus_prev_nxt = bus_s;
    idle_cnt_nxt = idle_cnt_r;
    if (mode_r != apm_pkg::APM_ACTIVE || bus_change)
      idle_cnt_nxt = '0;
    else if (!idle_qual)
      idle_cnt_nxt = idle_cnt_r + 1'b1;
  end

  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      bus_prev_r <= 1'b0;
      idle_cnt_r <= '0;
    end
    else
    begin
      bus_prev_r <= bus_prev_nxt;
      idle_cnt_r <= idle_cnt_nxt;
    end
  end

  // ==========================================================
  // wake switches
  apm_wake_if wif_bus ();
  apm_wake_if wif_aux ();
  logic sleeping;
  logic ws_wake;

  assign sleeping = (mode_r != apm_pkg::APM_ACTIVE);
  assign wif_bus.arm = sleeping && en_bus_ws;
  assign wif_bus.level = bus_s;
  assign wif_aux.arm = sleeping && en_aux_ws;
  assign wif_aux.level = sync2_r[S_AUX];
  assign ws_wake = wif_bus.wake || wif_aux.wake;

  apm_wake_debounce #(
    .DEBOUNCE_CYC(DEBOUNCE_CYC)
  ) u_ws_bus (
    .mclk(mclk),
    .srst(srst),
    .wif(wif_bus)
  );

  apm_wake_debounce #(
    .DEBOUNCE_CYC(DEBOUNCE_CYC)
  ) u_ws_aux (
    .mclk(mclk),
    .srst(srst),
    .wif(wif_aux)
  );

  // ==========================================================
  // power-mode state machine
  logic sleep_block;
  logic charger_wake;
  logic bus_wake_rise;
  logic bus_wake_change;

  // a rise made by our own weak pull-up is not bus activity
  assign bus_wake_rise = bus_rise && !bus_pin_weak_pullup;
  assign bus_wake_change = bus_change && !(bus_rise && bus_pin_weak_pullup);
  assign sleep_block = charger_s || chg_cur_s;
  assign charger_wake = charger_s && !uv_s;

  always_comb
  begin
    mode_nxt = mode_r;
    unique case (mode_r)
      apm_pkg::APM_ACTIVE:
        if (!sleep_block && idle_qual)
        begin
          if (en_bus_low && !bus_s)
            mode_nxt = apm_pkg::APM_SLEEP_BUS_LOW;
          else if (en_uv && uv_s)
            mode_nxt = apm_pkg::APM_SLEEP_UV;
        end
      apm_pkg::APM_SLEEP_BUS_LOW:
        if (charger_wake || bus_wake_rise || ws_wake)
          mode_nxt = apm_pkg::APM_ACTIVE;
      apm_pkg::APM_SLEEP_UV:
        if (charger_wake || bus_wake_change || ws_wake)
          mode_nxt = apm_pkg::APM_ACTIVE;
    endcase
  end

  always_ff @(posedge mclk)
  begin
    if (srst)
      mode_r <= apm_pkg::APM_ACTIVE;
    else
      mode_r <= mode_nxt;
  end

  // ==========================================================
  // registered function enables
  logic [7:0] out_r;
  logic [7:0] out_nxt;
  logic act_nxt;

  always_comb
  begin
    act_nxt = (mode_nxt == apm_pkg::APM_ACTIVE);
    out_nxt = 8'h00;
    out_nxt[0] = act_nxt;
    out_nxt[1] = act_nxt;
    out_nxt[2] = act_nxt;
    out_nxt[3] = act_nxt;
    out_nxt[4] = act_nxt && charge_safe;
    out_nxt[5] = act_nxt && discharge_safe;
    out_nxt[6] = !act_nxt && en_bus_ws;
    out_nxt[7] = !act_nxt && en_aux_ws;
  end

  always_ff @(posedge mclk)
  begin
    if (srst)
      out_r <= 8'h0f;
    else
      out_r <= out_nxt;
  end

  assign active_mode = out_r[0];
  assign measure_enable = out_r[1];
  assign coulomb_count_enable = out_r[2];
  assign auth_enable = out_r[3];
  assign charge_fet_drive_enable = out_r[4];
  assign discharge_fet_drive_enable = out_r[5];
  assign bus_pin_weak_pullup = out_r[6];
  assign aux_io_pin_weak_pullup = out_r[7];

endmodule

`default_nettype wire

// *** apm_pkg.sv ***
// constants for the active/sleep power-mode controller
// assumes a single 10 MHz clock and a plain register port with 8-bit data
`default_nettype none

package apm_pkg;

  // ==========================================================
  // clock and timing
  localparam int unsigned CLK_HZ = 10_000_000;
  localparam int unsigned SLEEP_TIMEOUT_MS = 2000;
  localparam int unsigned SLEEP_CYC = SLEEP_TIMEOUT_MS * (CLK_HZ / 1000);
  localparam int unsigned DEBOUNCE_MS = 100;
  localparam int unsigned DEBOUNCE_CYC = DEBOUNCE_MS * (CLK_HZ / 1000);
  localparam int unsigned CNT_W = 32;

  // ==========================================================
  // register map
  localparam logic [7:0] CTRL_ADDR = 8'h60;
  localparam logic [7:0] STAT_ADDR = 8'h61;
  localparam logic [7:0] CTRL_RST = 8'h00;

  // control fields
  localparam int unsigned BUS_PIN_WAKE_SWITCH_ENABLE_BIT = 1;
  localparam int unsigned AUX_PIN_WAKE_SWITCH_ENABLE_BIT = 2;
  localparam int unsigned SLEEP_ON_BUS_LOW_ENABLE_BIT = 5;
  localparam int unsigned SLEEP_ON_UNDERVOLTAGE_ENABLE_BIT = 6;

  // status fields
  localparam int unsigned STAT_ACTIVE_BIT = 0;
  localparam int unsigned STAT_SLEEP_BUS_LOW_BIT = 1;
  localparam int unsigned STAT_SLEEP_UV_BIT = 2;
  localparam int unsigned STAT_BUS_LEVEL_BIT = 3;
  localparam int unsigned STAT_UV_BIT = 4;
  localparam int unsigned STAT_CHARGER_BIT = 5;
  localparam int unsigned STAT_CHG_CURRENT_BIT = 6;
  localparam int unsigned STAT_IDLE_QUAL_BIT = 7;

  // ==========================================================
  // power-mode states
  typedef enum logic [2:0] {
    APM_ACTIVE = 3'b001,
    APM_SLEEP_BUS_LOW = 3'b010,
    APM_SLEEP_UV = 3'b100
  } apm_mode_t;

  // wake-switch states
  typedef enum logic [3:0] {
    APM_WS_IDLE = 4'b0001,
    APM_WS_PULLUP = 4'b0010,
    APM_WS_ARMED = 4'b0100,
    APM_WS_DEBOUNCE = 4'b1000
  } apm_ws_state_t;

endpackage

`default_nettype wire

// *** apm_wake_if.sv ***
// link between the power-mode controller and one wake-switch debouncer
// assumes both ends run on the same clock
`default_nettype none

interface apm_wake_if;
  logic arm;
  logic level;
  logic wake;

  modport ctl (output arm, output level, input wake);
  modport sw (input arm, input level, output wake);
endinterface

`default_nettype wire

// *** apm_wake_debounce.sv ***
// wake-switch debouncer for one pin
// assumes the pin level is already synchronised to mclk
`default_nettype none

module apm_wake_debounce #(
  parameter int unsigned DEBOUNCE_CYC = apm_pkg::DEBOUNCE_CYC
) (
  // clock and reset
  input wire logic mclk,
  input wire logic srst,
  // controller side
  apm_wake_if.sw wif
);

  // ==========================================================
  // state
  apm_pkg::apm_ws_state_t st_r;
  apm_pkg::apm_ws_state_t st_nxt;
  logic [apm_pkg::CNT_W-1:0] cnt_r;
  logic [apm_pkg::CNT_W-1:0] cnt_nxt;
  logic wake_r;
  logic wake_nxt;

  // ==========================================================
  // next state
  always_comb
  begin
    st_nxt = st_r;
    cnt_nxt = cnt_r;
    wake_nxt = 1'b0;
    if (!wif.arm)
    begin
      st_nxt = apm_pkg::APM_WS_IDLE;
      cnt_nxt = '0;
    end
    else
    begin
      unique case (st_r)
        apm_pkg::APM_WS_IDLE:
          st_nxt = apm_pkg::APM_WS_PULLUP;
        // wait for the weak pull-up to bring the pin high
        apm_pkg::APM_WS_PULLUP:
          if (wif.level)
            st_nxt = apm_pkg::APM_WS_ARMED;
        apm_pkg::APM_WS_ARMED:
          if (!wif.level)
          begin
            st_nxt = apm_pkg::APM_WS_DEBOUNCE;
            cnt_nxt = '0;
          end
        // low must hold for the whole debounce period
        apm_pkg::APM_WS_DEBOUNCE:
          if (wif.level)
            st_nxt = apm_pkg::APM_WS_ARMED;
          else if (cnt_r >= DEBOUNCE_CYC - 1)
          begin
            wake_nxt = 1'b1;
            st_nxt = apm_pkg::APM_WS_IDLE;
          end
          else
            cnt_nxt = cnt_r + 1'b1;
      endcase
    end
  end

  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      st_r <= apm_pkg::APM_WS_IDLE;
      cnt_r <= '0;
      wake_r <= 1'b0;
    end
    else
    begin
      st_r <= st_nxt;
      cnt_r <= cnt_nxt;
      wake_r <= wake_nxt;
    end
  end

  assign wif.wake = wake_r;

endmodule

`default_nettype wire

// *** apm_far_end.sv ***
// far side: host bus driver and pack wake switch
// assumes the bench sets host presence, host level and switch state
`default_nettype none

module apm_far_end (
  // bench controls
  input wire logic host_on,
  input wire logic host_low,
  input wire logic sw_aux,
  input wire logic sw_bus,
  // design pullups and pins
  input wire logic bus_pin_weak_pullup,
  input wire logic aux_io_pin_weak_pullup,
  output logic bus_line_in,
  output logic aux_io_pin_in
);
  timeunit 1ns;
  timeprecision 1ns;
  // ======
  // released lines fall to their pulldown unless weakly pulled up
  // with the host gone, a switch on the bus pin can pull it to ground
  assign bus_line_in = host_on ? !host_low : bus_pin_weak_pullup && !sw_bus;
  assign aux_io_pin_in = aux_io_pin_weak_pullup && !sw_aux;
endmodule

`default_nettype wire

// *** apm_power_mode_ctrl_props.sv ***
// port checker for the power-mode controller
// assumes binding into apm_power_mode_ctrl, one clock
`default_nettype none

module apm_props_chk #(
  parameter int unsigned SLEEP_CYC = 20,
  parameter int unsigned DEBOUNCE_CYC = 10
) (
  // clock and reset
  input wire logic mclk,
  input wire logic srst,
  // register writes
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  // sensed inputs
  input wire logic bus_line_in,
  input wire logic charger_detect_in,
  input wire logic charge_safe,
  // outputs
  input wire logic active_mode,
  input wire logic measure_enable,
  input wire logic coulomb_count_enable,
  input wire logic charge_fet_drive_enable,
  input wire logic bus_pin_weak_pullup,
  input wire logic aux_io_pin_weak_pullup
);
  // ======
  // control shadow, charger history, raw bus idle count
  logic [7:0] ctl_r, ctl_nxt;
  logic [4:0] chg_r, chg_nxt;
  logic [31:0] idle_r, idle_nxt;
  logic bus_r;

  always_comb
  begin
    ctl_nxt = srst ? 8'h00 : (reg_wr && reg_addr == 8'h60) ? reg_wdata : ctl_r;
    chg_nxt = srst ? 5'h00 : {chg_r[3:0], charger_detect_in};
    idle_nxt = (srst || bus_line_in != bus_r) ? 32'h0 : idle_r + 32'h1;
  end

  always_ff @(posedge mclk)
  begin
    ctl_r <= ctl_nxt;
    chg_r <= chg_nxt;
    idle_r <= idle_nxt;
    bus_r <= bus_line_in;
  end

  // ======
  // assertions
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (srst);

  a_start_active: assert property (
    $fell(srst) |-> active_mode && !charge_fet_drive_enable)
    else $error("not active after reset");
  a_mode_outs: assert property (
    measure_enable == active_mode && coulomb_count_enable == active_mode)
    else $error("function enables differ from mode");
  a_fet_follow: assert property (
    active_mode && $past(active_mode) && !$past(srst)
    |-> charge_fet_drive_enable == $past(charge_safe))
    else $error("charge drive not following verdict");
  a_fet_off_sleep: assert property (
    !active_mode |-> !charge_fet_drive_enable)
    else $error("charge drive in sleep");
  a_no_chg_sleep: assert property (
    $fell(active_mode) |-> chg_r != 5'h1f)
    else $error("sleep with charger present");
  a_sleep_idle: assert property (
    $fell(active_mode) |-> idle_r >= SLEEP_CYC)
    else $error("sleep before bus idle timeout");
  a_sleep_en: assert property (
    $fell(active_mode) |-> ctl_r[5] || ctl_r[6])
    else $error("sleep with both enables clear");
  a_pullup_en: assert property (
    (aux_io_pin_weak_pullup |-> ctl_r[2]) and (bus_pin_weak_pullup |-> ctl_r[1]))
    else $error("pullup without its enable");

  c_sleep: cover property ($fell(active_mode));
  c_wake: cover property ($rose(active_mode));
  c_aux_arm: cover property ($rose(aux_io_pin_weak_pullup));
endmodule

bind apm_power_mode_ctrl apm_props_chk #(
  .SLEEP_CYC(SLEEP_CYC),
  .DEBOUNCE_CYC(DEBOUNCE_CYC)
) i_apm_props_chk (
  .mclk(mclk), .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
  .bus_line_in(bus_line_in), .charger_detect_in(charger_detect_in),
  .charge_safe(charge_safe), .active_mode(active_mode), .measure_enable(measure_enable),
  .coulomb_count_enable(coulomb_count_enable),
  .charge_fet_drive_enable(charge_fet_drive_enable),
  .bus_pin_weak_pullup(bus_pin_weak_pullup),
  .aux_io_pin_weak_pullup(aux_io_pin_weak_pullup)
);

`default_nettype wire

// *** tb_top.sv ***
// bench for the power-mode controller with far-side model
// assumes short timeout and debounce counts
`default_nettype none

module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int SC = 20;
  localparam int DBC = 10;
  // ======
  // signals
  logic mclk = 1'b0, srst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
  logic charger_detect_in = 1'b0, charge_current_in = 1'b0, cell_undervoltage_in = 1'b0;
  logic charge_safe = 1'b0, discharge_safe = 1'b0, host_on = 1'b1, host_low = 1'b0;
  logic sw_aux = 1'b0, sw_bus = 1'b0, bus_line_in, aux_io_pin_in, active_mode, measure_enable;
  logic coulomb_count_enable, auth_enable, charge_fet_drive_enable;
  logic discharge_fet_drive_enable, bus_pin_weak_pullup, aux_io_pin_weak_pullup;
  int fail_count = 0;
  int num_checks = 0;
  typedef struct {logic [7:0] a; logic [7:0] d; logic [7:0] ra; logic [7:0] e;} apm_row_t;
  apm_row_t rows [4] = '{'{8'h60, 8'ha5, 8'h60, 8'ha5}, '{8'h61, 8'hff, 8'h60, 8'ha5},
    '{8'h3c, 8'h5a, 8'h3c, 8'h00}, '{8'h60, 8'h00, 8'h60, 8'h00}};

  always #50 mclk = ~mclk;

  apm_power_mode_ctrl #(.SLEEP_CYC(SC), .DEBOUNCE_CYC(DBC)) i_apm_power_mode_ctrl (
    .mclk(mclk), .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .bus_line_in(bus_line_in),
    .aux_io_pin_in(aux_io_pin_in), .charger_detect_in(charger_detect_in),
    .charge_current_in(charge_current_in), .cell_undervoltage_in(cell_undervoltage_in),
    .charge_safe(charge_safe), .discharge_safe(discharge_safe), .active_mode(active_mode),
    .measure_enable(measure_enable), .coulomb_count_enable(coulomb_count_enable),
    .auth_enable(auth_enable), .charge_fet_drive_enable(charge_fet_drive_enable),
    .discharge_fet_drive_enable(discharge_fet_drive_enable),
    .bus_pin_weak_pullup(bus_pin_weak_pullup),
    .aux_io_pin_weak_pullup(aux_io_pin_weak_pullup)
  );

  apm_far_end i_apm_far_end (
    .host_on(host_on), .host_low(host_low), .sw_aux(sw_aux), .sw_bus(sw_bus),
    .bus_pin_weak_pullup(bus_pin_weak_pullup), .aux_io_pin_weak_pullup(aux_io_pin_weak_pullup),
    .bus_line_in(bus_line_in), .aux_io_pin_in(aux_io_pin_in)
  );

  // ======
  // tasks
  task automatic chk(input logic [7:0] s, input logic [7:0] e);
    num_checks++;
    if (s !== e)
    begin
      fail_count++;
      $display("wrong value at %0t: saw %h, expected %h", $time, s, e);
    end
  endtask

  task automatic summarize();
    $display("checks %0d, mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0)
    begin
      $display("== PASSED ==");
    end
    else
    begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge mclk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge mclk);
    reg_rd <= 1'b0;
    @(negedge mclk);
    chk(reg_rdata, e);
  endtask

  task automatic hold(input int n, input logic v);
    repeat (n)
    begin
      @(negedge mclk);
      chk(active_mode, v);
    end
  endtask

  task automatic wt(input logic v, input int n);
    for (int i = 0; i < n && active_mode !== v; i++)
    begin
      @(negedge mclk);
    end
    chk(active_mode, v);
    if (active_mode !== v)
    begin
      summarize();
    end
  endtask

  // ======
  // sequence
  initial
  begin
    repeat (2) @(posedge mclk);
    srst <= 1'b0;
    @(negedge mclk);
    chk({active_mode, charge_fet_drive_enable, aux_io_pin_weak_pullup}, 3'b100);
    @(posedge mclk);
    charge_safe <= 1'b1;
    repeat (3) @(negedge mclk);
    chk({charge_fet_drive_enable, discharge_fet_drive_enable}, 2'b10);
    @(posedge mclk);
    discharge_safe <= 1'b1;
    repeat (2) @(negedge mclk);
    chk({charge_fet_drive_enable, discharge_fet_drive_enable}, 2'b11);
    foreach (rows[i])
    begin
      wr(rows[i].a, rows[i].d);
      rd(rows[i].ra, rows[i].e);
    end
    @(posedge mclk);
    host_low <= 1'b1;
    cell_undervoltage_in <= 1'b1;
    hold(3 * SC, 1'b1);
    @(posedge mclk);
    charger_detect_in <= 1'b1;
    hold(3, 1'b1);
    wr(8'h60, 8'h60);
    hold(3 * SC, 1'b1);
    @(posedge mclk);
    charge_current_in <= 1'b1;
    hold(3, 1'b1);
    @(posedge mclk);
    charger_detect_in <= 1'b0;
    hold(3 * SC, 1'b1);
    wr(8'h60, 8'h00);
    charge_current_in <= 1'b0;
    cell_undervoltage_in <= 1'b0;
    host_low <= 1'b0;
    wr(8'h60, 8'h20);
    repeat (4)
    begin
      @(posedge mclk);
      host_low <= ~host_low;
      hold(SC - 5, 1'b1);
    end
    @(posedge mclk);
    host_low <= 1'b1;
    hold(SC - 2, 1'b1);
    wt(1'b0, 12);
    chk({measure_enable, coulomb_count_enable, auth_enable}, 3'b000);
    chk(discharge_fet_drive_enable, 1'b0);
    rd(8'h60, 8'h20);
    @(posedge mclk);
    host_low <= 1'b0;
    wt(1'b1, 6);
    chk({charge_fet_drive_enable, discharge_fet_drive_enable}, 2'b11);
    wr(8'h60, 8'h40);
    cell_undervoltage_in <= 1'b1;
    wt(1'b0, SC + 8);
    @(posedge mclk);
    host_low <= 1'b1;
    wt(1'b1, 6);
    wt(1'b0, SC + 8);
    @(posedge mclk);
    charger_detect_in <= 1'b1;
    hold(6, 1'b0);
    @(posedge mclk);
    cell_undervoltage_in <= 1'b0;
    wt(1'b1, 6);
    @(posedge mclk);
    charger_detect_in <= 1'b0;
    wr(8'h60, 8'h24);
    wt(1'b0, SC + 8);
    chk({aux_io_pin_weak_pullup, bus_pin_weak_pullup}, 2'b10);
    hold(4, 1'b0);
    @(posedge mclk);
    sw_aux <= 1'b1;
    hold(DBC - 5, 1'b0);
    @(posedge mclk);
    sw_aux <= 1'b0;
    hold(DBC, 1'b0);
    @(posedge mclk);
    sw_aux <= 1'b1;
    hold(DBC - 2, 1'b0);
    wt(1'b1, 10);
    @(posedge mclk);
    sw_aux <= 1'b0;
    wr(8'h60, 8'h22);
    wt(1'b0, SC + 8);
    chk({aux_io_pin_weak_pullup, bus_pin_weak_pullup}, 2'b01);
    @(posedge mclk);
    host_on <= 1'b0;
    hold(DBC, 1'b0);
    @(posedge mclk);
    sw_bus <= 1'b1;
    hold(DBC - 2, 1'b0);
    wt(1'b1, 10);
    summarize();
  end
endmodule

`default_nettype wire
